// ===== rtl/irq_prio_ctrl.sv
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "irq_prio_consts.svh"
// Function
// [RULE_01] serial request is the OR of its receive and transmit done flags
// [RULE_02] serial flags stay set on vectoring; only a software write clears them
// [RULE_03] both serial ports behave alike; second port uses bit 4 of ext registers
// [RULE_04] ext enable: data channel 7, serial2 4, two-wire 1, usb 0; resets zero
// [RULE_05] main enable: global 7, reserved 6, bits 5..0 per source; resets zero
// [RULE_06] global gate low blocks all; high lets each enabled source through
// [RULE_07] each source is masked by its own enable bit independently
// [RULE_08] main priority: bits 5..0 per source, 7 and 6 reserved; resets zero
// [RULE_09] one level bit per source, 1 high; ext priority laid out like ext enable
// [RULE_10] high request nests above a running low-level handler
// [RULE_11] nothing vectors while a high-level handler runs
// [RULE_12] high-level request wins over a simultaneous low-level one
// [RULE_13] equal levels resolved by fixed polling order, external pin 0 first
// [RULE_14] flags sampled once per machine cycle, polled next; no memory of denial
// [RULE_15] acknowledge issues a vector call with the per-source fixed address
// [RULE_16] only the return-from-handler instruction clears the in-progress level
// [RULE_17] reserved and unused register bits read zero and ignore writes
module irq_prio_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [9:0] src_req,
  input wire logic [1:0] rx_done_set,
  input wire logic [1:0] tx_done_set,
  input wire irq_prio_pkg::core_ctl_t core_ctl,
  output irq_prio_pkg::vector_call_t hardware_vector_call
);

  // ==========================================================
  // helpers
  function automatic logic [9:0] per_source(input logic [7:0] main_r, input logic [7:0] ext_r);
    logic [9:0] v;
    v = 10'h000;
    v[irq_prio_pkg::SRC_EXTPIN0] = main_r[`MAIN_EXTPIN0_BIT];
    v[irq_prio_pkg::SRC_SERIAL2] = ext_r[`EXT_SERIAL2_BIT];
    v[irq_prio_pkg::SRC_TIMER0] = main_r[`MAIN_TIMER0_BIT];
    v[irq_prio_pkg::SRC_TWOWIRE] = ext_r[`EXT_TWOWIRE_BIT];
    v[irq_prio_pkg::SRC_EXTPIN1] = main_r[`MAIN_EXTPIN1_BIT];
    v[irq_prio_pkg::SRC_DATACHAN] = ext_r[`EXT_DATACHAN_BIT];
    v[irq_prio_pkg::SRC_TIMER1] = main_r[`MAIN_TIMER1_BIT];
    v[irq_prio_pkg::SRC_USB] = ext_r[`EXT_USB_BIT];
    v[irq_prio_pkg::SRC_SERIAL1] = main_r[`MAIN_SERIAL1_BIT];
    v[irq_prio_pkg::SRC_TIMER2] = main_r[`MAIN_TIMER2_BIT];
    return v;
  endfunction : per_source

  function automatic logic [15:0] vector_of(input logic [3:0] src);
    case (src)
      4'h0: vector_of = `VEC_EXTPIN0;
      4'h1: vector_of = `VEC_SERIAL2;
      4'h2: vector_of = `VEC_TIMER0;
      4'h3: vector_of = `VEC_TWOWIRE;
      4'h4: vector_of = `VEC_EXTPIN1;
      4'h5: vector_of = `VEC_DATACHAN;
      4'h6: vector_of = `VEC_TIMER1;
      4'h7: vector_of = `VEC_USB;
      4'h8: vector_of = `VEC_SERIAL1;
      default: vector_of = `VEC_TIMER2;
    endcase
  endfunction : vector_of

  // loop runs downwards so the lowest set index is the last one kept
  function automatic logic [3:0] first_set(input logic [9:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 9; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : first_set

  function automatic logic [9:0] word_idx(input logic [11:0] a);
    return a[11:2];
  endfunction : word_idx

  // ==========================================================
  // registers
  logic [7:0] irq_enable_ext_q;
  logic [7:0] irq_enable_main_q;
  logic [7:0] irq_priority_ext_q;
  logic [7:0] irq_priority_main_q;
  logic [1:0] rx_done_flag_q;
  logic [1:0] tx_done_flag_q;
  logic hi_active_q;
  logic lo_active_q;
  logic [9:0] sample_q;
  logic sample_valid_q;

  // ==========================================================
  // bus write side
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic do_write;
  logic [9:0] widx;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  // a write lands once both halves are held; a pending answer stalls the next
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign widx = word_idx(awaddr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata[7:0];
      wlane_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  logic hit_w;
  always_comb begin
    case (widx)
      `IRQ_ENABLE_EXT_IDX, `IRQ_ENABLE_MAIN_IDX, `IRQ_PRIORITY_EXT_IDX, `IRQ_PRIORITY_MAIN_IDX,
      `IRQ_STATUS_IDX, `SERIAL_FLAGS_IDX: hit_w = 1'b1;
      default: hit_w = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= hit_w ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // only byte lane 0 carries data; without its strobe nothing is stored
  logic wr_en;
  assign wr_en = do_write && wlane_q;

  // each register keeps only its writable bits, so reserved ones read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_ext_q <= `IRQ_REG_RESET; // RULE_04
    end else if (wr_en && widx == `IRQ_ENABLE_EXT_IDX) begin
      irq_enable_ext_q <= wdata_q & `IRQ_EXT_MASK; // RULE_17
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_main_q <= `IRQ_REG_RESET; // RULE_05
    end else if (wr_en && widx == `IRQ_ENABLE_MAIN_IDX) begin
      irq_enable_main_q <= wdata_q & `IRQ_MAIN_EN_MASK; // RULE_17
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_priority_ext_q <= `IRQ_REG_RESET; // RULE_09
    end else if (wr_en && widx == `IRQ_PRIORITY_EXT_IDX) begin
      irq_priority_ext_q <= wdata_q & `IRQ_EXT_MASK; // RULE_17
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_priority_main_q <= `IRQ_REG_RESET; // RULE_08
    end else if (wr_en && widx == `IRQ_PRIORITY_MAIN_IDX) begin
      irq_priority_main_q <= wdata_q & `IRQ_MAIN_PRI_MASK; // RULE_17
    end
  end

  // ==========================================================
  // serial done flags: write one to clear, a set in the same cycle wins
  logic [3:0] flag_clr;
  assign flag_clr = (wr_en && widx == `SERIAL_FLAGS_IDX) ? wdata_q[3:0] & `SERIAL_FLAGS_MASK : 4'h0;

  for (genvar p = 0; p < 2; p++) begin : g_serial
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rx_done_flag_q[p] <= 1'b0;
        tx_done_flag_q[p] <= 1'b0;
      end else begin
        rx_done_flag_q[p] <= rx_done_set[p] | (rx_done_flag_q[p] & ~flag_clr[2*p]); // RULE_02 RULE_03
        tx_done_flag_q[p] <= tx_done_set[p] | (tx_done_flag_q[p] & ~flag_clr[2*p+1]); // RULE_02 RULE_03
      end
    end
  end

  // ==========================================================
  // sampling and arbitration
  logic [9:0] req_all;
  logic [9:0] enabled;
  logic [9:0] level;
  always_comb begin
    req_all = src_req;
    req_all[irq_prio_pkg::SRC_SERIAL1] = rx_done_flag_q[0] | tx_done_flag_q[0]; // RULE_01
    req_all[irq_prio_pkg::SRC_SERIAL2] = rx_done_flag_q[1] | tx_done_flag_q[1]; // RULE_01 RULE_03
  end
  assign enabled = per_source(irq_enable_main_q, irq_enable_ext_q) // RULE_07
                   & {10{irq_enable_main_q[`GLOBAL_GATE_BIT]}}; // RULE_06
  assign level = per_source(irq_priority_main_q, irq_priority_ext_q); // RULE_09

  logic take_call;
  // every tick overwrites the sample, so a denied request is not remembered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_q <= 10'h000;
      sample_valid_q <= 1'b0;
    end else if (core_ctl.machine_tick) begin
      sample_q <= req_all & enabled; // RULE_14
      sample_valid_q <= 1'b1;
    end else if (take_call) begin
      sample_valid_q <= 1'b0;
    end
  end

  logic [9:0] hi_req;
  logic [9:0] lo_req;
  logic [9:0] cand;
  logic cand_hi;
  // enables are applied again at poll time, so clearing a gate after the
  // sample was taken still stops the call
  assign hi_req = sample_q & enabled & level & {10{sample_valid_q}};
  assign lo_req = sample_q & enabled & ~level & {10{sample_valid_q}};
  assign cand_hi = |hi_req; // RULE_12
  assign cand = cand_hi ? hi_req : lo_req;
  assign take_call = core_ctl.final_cycle && !core_ctl.block_instr && !hi_active_q // RULE_11
                     && (cand_hi || (!lo_active_q && |lo_req)); // RULE_10

  logic [3:0] pick;
  assign pick = first_set(cand); // RULE_13

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hardware_vector_call <= '0;
    end else begin
      hardware_vector_call.call <= take_call; // RULE_15
      hardware_vector_call.level <= cand_hi;
      hardware_vector_call.source <= pick;
      hardware_vector_call.addr <= vector_of(pick); // RULE_15
    end
  end

  // ==========================================================
  // in-progress levels
  // a call wins over a return in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_active_q <= 1'b0;
    end else if (take_call && cand_hi) begin
      hi_active_q <= 1'b1;
    end else if (core_ctl.return_from_handler_instr && !take_call) begin
      hi_active_q <= 1'b0; // RULE_16
    end
  end

  // a return closes the high level first when both are in progress
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_active_q <= 1'b0;
    end else if (take_call && !cand_hi) begin
      lo_active_q <= 1'b1;
    end else if (core_ctl.return_from_handler_instr && !take_call && !hi_active_q) begin
      lo_active_q <= 1'b0; // RULE_16
    end
  end

  // ==========================================================
  // bus read side
  assign s_axi_arready = !s_axi_rvalid;

  // reads have no side effects; the upper lanes read zero
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (word_idx(s_axi_araddr))
      `IRQ_ENABLE_EXT_IDX: rd_byte = irq_enable_ext_q;
      `IRQ_ENABLE_MAIN_IDX: rd_byte = irq_enable_main_q;
      `IRQ_PRIORITY_EXT_IDX: rd_byte = irq_priority_ext_q;
      `IRQ_PRIORITY_MAIN_IDX: rd_byte = irq_priority_main_q;
      `IRQ_STATUS_IDX: rd_byte = {6'h00, hi_active_q, lo_active_q};
      `SERIAL_FLAGS_IDX: rd_byte = {4'h0, tx_done_flag_q[1], rx_done_flag_q[1], tx_done_flag_q[0], rx_done_flag_q[0]};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : irq_prio_ctrl

// ===== rtl/irq_prio_consts.svh
`ifndef IRQ_PRIO_CONSTS_SVH
`define IRQ_PRIO_CONSTS_SVH
// ==========================================================
// register indices (byte address is four times the index)
`define IRQ_ENABLE_EXT_IDX 10'h0A7
`define IRQ_ENABLE_MAIN_IDX 10'h0A8
`define IRQ_PRIORITY_EXT_IDX 10'h0B7
`define IRQ_PRIORITY_MAIN_IDX 10'h0B8
`define IRQ_STATUS_IDX 10'h0C0
`define SERIAL_FLAGS_IDX 10'h0C1
// ==========================================================
// reset values and writable bit masks
`define IRQ_REG_RESET 8'h00
`define IRQ_EXT_MASK 8'h93
`define IRQ_MAIN_EN_MASK 8'hBF
`define IRQ_MAIN_PRI_MASK 8'h3F
`define SERIAL_FLAGS_MASK 4'hF
// ==========================================================
// field positions
`define GLOBAL_GATE_BIT 7
`define EXT_DATACHAN_BIT 7
`define EXT_SERIAL2_BIT 4
`define EXT_TWOWIRE_BIT 1
`define EXT_USB_BIT 0
`define MAIN_TIMER2_BIT 5
`define MAIN_SERIAL1_BIT 4
`define MAIN_TIMER1_BIT 3
`define MAIN_EXTPIN1_BIT 2
`define MAIN_TIMER0_BIT 1
`define MAIN_EXTPIN0_BIT 0
// ==========================================================
// vector addresses
`define VEC_EXTPIN0 16'h0003
`define VEC_SERIAL2 16'h004B
`define VEC_TIMER0 16'h000B
`define VEC_TWOWIRE 16'h0043
`define VEC_EXTPIN1 16'h0013
`define VEC_DATACHAN 16'h003B
`define VEC_TIMER1 16'h001B
`define VEC_USB 16'h0033
`define VEC_SERIAL1 16'h0023
`define VEC_TIMER2 16'h002B
// ==========================================================
// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== rtl/irq_prio_pkg.sv
package irq_prio_pkg;
  // polling order, index 0 polled first
  typedef enum logic [3:0] {
    SRC_EXTPIN0, SRC_SERIAL2, SRC_TIMER0, SRC_TWOWIRE, SRC_EXTPIN1,
    SRC_DATACHAN, SRC_TIMER1, SRC_USB, SRC_SERIAL1, SRC_TIMER2
  } src_t;

  typedef struct packed {
    logic machine_tick;
    logic final_cycle;
    logic block_instr;
    logic return_from_handler_instr;
  } core_ctl_t;

  typedef struct packed {
    logic call;
    logic level;
    logic [3:0] source;
    logic [15:0] addr;
  } vector_call_t;
endpackage : irq_prio_pkg

// ===== tb/irq_prio_monitor.sv
`timescale 1ns/1ps
module irq_prio_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire irq_prio_pkg::core_ctl_t core_ctl,
  input wire irq_prio_pkg::vector_call_t hardware_vector_call
);
  localparam logic [15:0] VEC [10] = '{16'h0003, 16'h004B, 16'h000B, 16'h0043, 16'h0013,
    16'h003B, 16'h001B, 16'h0033, 16'h0023, 16'h002B};
  logic hi_q;
  logic lo_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // handler levels in progress, rebuilt from calls and returns
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end else if (hardware_vector_call.call) begin
      hi_q <= hi_q | hardware_vector_call.level;
      lo_q <= lo_q | !hardware_vector_call.level;
    end else if (core_ctl.return_from_handler_instr) begin
      hi_q <= 1'b0;
      lo_q <= lo_q & hi_q;
    end
  end
  sequence s_call;
    hardware_vector_call.call;
  endsequence
  sequence s_pair_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_no_decide;
    !core_ctl.final_cycle || core_ctl.block_instr;
  endsequence
  a_call_pulse: assert property (s_call |=> !hardware_vector_call.call)
    else $error("call wider than one cycle");
  a_call_vector: assert property (s_call |-> hardware_vector_call.addr == VEC[hardware_vector_call.source])
    else $error("wrong vector address");
  a_call_phase: assert property (s_no_decide |=> !hardware_vector_call.call)
    else $error("call outside final cycle");
  a_high_blocks: assert property (hi_q |-> !hardware_vector_call.call)
    else $error("call during high handler");
  a_low_nests: assert property (lo_q ##0 s_call |-> hardware_vector_call.level)
    else $error("low call during low handler");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_ar_blocked: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late or address taken while busy");
  a_aw_blocked: assert property (s_pair_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid && !s_axi_awready)
    else $error("write answer late or address taken while busy");
endmodule : irq_prio_monitor
bind irq_prio_ctrl irq_prio_monitor mon_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .core_ctl(core_ctl),
  .hardware_vector_call(hardware_vector_call));

// ===== tb/core_seq.sv
`timescale 1ns/1ps
module core_seq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ret_go,
  input wire logic blk,
  output irq_prio_pkg::core_ctl_t core_ctl
);
  logic [1:0] phase_q;
  logic ret_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  always_ff @(posedge aclk) begin
    ret_q <= aresetn && ret_go;
  end
  // four clocks per machine cycle, sample first, decide last
  assign core_ctl.machine_tick = aresetn && (phase_q == 2'h0);
  assign core_ctl.final_cycle = (phase_q == 2'h3);
  assign core_ctl.block_instr = blk || ret_q;
  assign core_ctl.return_from_handler_instr = ret_q;
endmodule : core_seq

// ===== tb/test_two_level_irq_priority_enable.sv
`timescale 1ns/1ps
module test_two_level_irq_priority_enable;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0] rx_done_set = 2'h0, tx_done_set = 2'h0;
  logic [9:0] src_req = 10'h000;
  logic ret_go = 1'b0, blk = 1'b0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire irq_prio_pkg::core_ctl_t core_ctl;
  wire irq_prio_pkg::vector_call_t hardware_vector_call;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  logic [15:0] vec [10] = '{16'h0003, 16'h004B, 16'h000B, 16'h0043, 16'h0013,
    16'h003B, 16'h001B, 16'h0033, 16'h0023, 16'h002B};
  logic [11:0] ra [4] = '{12'h29C, 12'h2A0, 12'h2DC, 12'h2E0};
  logic [7:0] rm [4] = '{8'h93, 8'hBF, 8'h93, 8'h3F};
  irq_prio_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_req, .rx_done_set, .tx_done_set,
    .core_ctl, .hardware_vector_call);
  core_seq core_u (.aclk, .aresetn, .ret_go, .blk, .core_ctl);
  initial begin
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      close_out();
    end
  end
  // ==========================================
  // shared tasks
  task automatic close_out();
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q,
                     output logic [1:0] r);
    logic na;
    logic nw;
    q = 32'h00000000;
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        @(negedge aclk);
        na = s_axi_awvalid && s_axi_awready;
        nw = s_axi_wvalid && s_axi_wready;
        @(posedge aclk);
        if (na) s_axi_awvalid <= 1'b0;
        if (nw) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !na) || (s_axi_wvalid && !nw));
      s_axi_bready <= 1'b1;
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      q = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
    end
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b1, a, d, q, r);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b0, a, 8'h00, q, r);
    chk(q, e, n);
  endtask : rc
  task automatic setsrc(input logic [9:0] v);
    @(posedge aclk);
    src_req <= v;
  endtask : setsrc
  task automatic ret();
    @(posedge aclk);
    ret_go <= 1'b1;
    @(posedge aclk);
    ret_go <= 1'b0;
  endtask : ret
  task automatic wc(input logic e, input logic [3:0] s, input logic l);
    logic got;
    got = 1'b0;
    repeat (40) begin
      @(negedge aclk);
      if (hardware_vector_call.call === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
    chk(got, e, "call");
    if (got && e) begin
      chk(hardware_vector_call.source, s, "source");
      chk(hardware_vector_call.level, l, "level");
      chk(hardware_vector_call.addr, vec[s], "vector");
    end
  endtask : wc
  // ==========================================
  // scenarios
  task automatic regs_check();
    logic [31:0] q;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) rc(ra[i], 32'h0, "reset");
    for (int i = 0; i < 4; i++) begin
      wr(ra[i], 8'hFF);
      rc(ra[i], {24'h0, rm[i]}, "mask");
      wr(ra[i], 8'h00);
    end
    s_axi_wstrb <= 4'hE;
    wr(ra[1], 8'hBF);
    s_axi_wstrb <= 4'hF;
    rc(ra[1], 32'h0, "nolane");
    bus(1'b0, 12'h010, 8'h00, q, r);
    chk(r, 2'h2, "rresp");
    bus(1'b1, 12'h014, 8'h5A, q, r);
    chk(r, 2'h2, "bresp");
  endtask : regs_check
  task automatic poll_order();
    wr(12'h2A0, 8'hBF);
    wr(12'h29C, 8'h93);
    setsrc(10'h3FF);
    rx_done_set <= 2'h3;
    @(posedge aclk);
    rx_done_set <= 2'h0;
    for (int i = 0; i < 10; i++) begin
      wc(1'b1, i[3:0], 1'b0);
      if (i == 8) rc(12'h304, 32'h1, "flags");
      setsrc(src_req & ~(10'h001 << i));
      if (i == 1) wr(12'h304, 8'h04);
      if (i == 8) wr(12'h304, 8'h01);
      repeat (8) @(posedge aclk);
      ret();
    end
  endtask : poll_order
  task automatic serial_flags();
    wr(12'h2A0, 8'h90);
    wr(12'h29C, 8'h00);
    @(posedge aclk);
    tx_done_set <= 2'h1;
    @(posedge aclk);
    tx_done_set <= 2'h0;
    wc(1'b1, 4'h8, 1'b0);
    ret();
    wc(1'b1, 4'h8, 1'b0);
    wr(12'h304, 8'h02);
    repeat (8) @(posedge aclk);
    ret();
    wc(1'b0, 4'h0, 1'b0);
  endtask : serial_flags
  task automatic levels();
    wr(12'h2A0, 8'hBF);
    wr(12'h2E0, 8'h20);
    setsrc(10'h201);
    wc(1'b1, 4'h9, 1'b1);
    setsrc(10'h001);
    wc(1'b0, 4'h0, 1'b0);
    rc(12'h300, 32'h2, "status");
    ret();
    wc(1'b1, 4'h0, 1'b0);
    setsrc(10'h200);
    wc(1'b1, 4'h9, 1'b1);
    rc(12'h300, 32'h3, "status");
    setsrc(10'h000);
    repeat (8) @(posedge aclk);
    ret();
    rc(12'h300, 32'h1, "status");
    ret();
    rc(12'h300, 32'h0, "status");
    wr(12'h2E0, 8'h00);
    wr(12'h29C, 8'h10);
    wr(12'h2DC, 8'h10);
    rx_done_set <= 2'h2;
    @(posedge aclk);
    rx_done_set <= 2'h0;
    setsrc(10'h001);
    wc(1'b1, 4'h1, 1'b1);
    wr(12'h304, 8'h04);
    setsrc(10'h000);
    repeat (8) @(posedge aclk);
    ret();
    wr(12'h2DC, 8'h00);
    wr(12'h29C, 8'h00);
  endtask : levels
  task automatic gating();
    wr(12'h2A0, 8'h3F);
    setsrc(10'h005);
    wc(1'b0, 4'h0, 1'b0);
    wr(12'h2A0, 8'h81);
    blk <= 1'b1;
    repeat (12) @(posedge aclk);
    src_req <= 10'h000;
    repeat (8) @(posedge aclk);
    blk <= 1'b0;
    wc(1'b0, 4'h0, 1'b0);
    setsrc(10'h005);
    wc(1'b1, 4'h0, 1'b0);
    setsrc(10'h004);
    repeat (8) @(posedge aclk);
    ret();
    wc(1'b0, 4'h0, 1'b0);
  endtask : gating
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    regs_check();
    poll_order();
    serial_flags();
    levels();
    gating();
    close_out();
  end
endmodule : test_two_level_irq_priority_enable
